/* hw/two_wire_if.sv */
/*
  Open-drain clock and data pair joining the master and slave ends.
  Assumes pull-ups: a line is low when any party enables its driver.
*/
`timescale 1ns/100ps
interface two_wire_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic scl_s_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_m_oe | scl_s_oe);
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
  modport slave  (input scl, input sda, output scl_s_oe, output sda_s_oe);
endinterface

/* hw/two_wire_master.sv */
/*
  Simple master end: one write or read byte per command, clock from a divider.
  Assumes the master modport of the two-wire interface and a single master on the bus.
*/
`timescale 1ns/100ps
module two_wire_master
  import two_wire_pkg::*;
(
  // System
  input  wire logic       clock,
  input  wire logic       rst,
  // Command
  input  wire logic       cmd_valid,
  input  wire logic [6:0] cmd_addr,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_busy,
  output logic [7:0]      rd_data,
  output logic            nacked,
  output logic            lost,
  // Bus
  two_wire_if.master      bus
);
  typedef enum {M_IDLE, M_START, M_BITS, M_STOP} mstate_t;
  mstate_t     st;
  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic [15:0] div;
  logic [1:0]  ph;
  logic [4:0]  nbit;
  logic [17:0] frame;
  logic        scl_oe;
  logic        sda_oe;
  always_ff @(posedge clock) begin
    scl_s <= {scl_s[0], bus.scl};
    sda_s <= {sda_s[0], bus.sda};
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= M_IDLE; div <= 16'h0000; ph <= 2'h0; nbit <= 5'h00; frame <= 18'h00000;
      scl_oe <= 1'b0; sda_oe <= 1'b0; cmd_busy <= 1'b0;
      rd_data <= 8'h00; nacked <= 1'b0; lost <= 1'b0;
    end else begin
      case (st)
        M_IDLE: if (cmd_valid && scl_s[1] && sda_s[1]) begin
          // Address, direction, ack slot, data byte, final ack/nack slot.
          frame    <= {cmd_addr, cmd_read, 1'b1, cmd_read ? 8'hff : cmd_data, 1'b1};
          cmd_busy <= 1'b1; nacked <= 1'b0; lost <= 1'b0;
          sda_oe   <= 1'b1; div <= 16'h0000; st <= M_START;
        end
        M_START: if (div == 16'(HALF_CYCLES)) begin
          scl_oe <= 1'b1; div <= 16'h0000; ph <= 2'h0; nbit <= 5'h00; st <= M_BITS;
        end else div <= div + 16'h0001;
        M_BITS: begin
          if (div != 16'(HALF_CYCLES)) div <= div + 16'h0001;
          else if (ph == 2'h0) begin
            sda_oe <= ~frame[17]; ph <= 2'h1; div <= 16'h0000;
          end else if (ph == 2'h1) begin
            scl_oe <= 1'b0; ph <= 2'h2; div <= 16'h0000;
          end else if (!scl_s[1]) begin
            div <= div;
          end else begin
            if (!frame[17] == 1'b0 && !sda_s[1] && !(nbit == 5'h08 || nbit == 5'h11))
              lost <= ~cmd_read || nbit < 5'h09;
            if ((nbit == 5'h08 || (nbit == 5'h11 && !cmd_read)) && sda_s[1]) nacked <= 1'b1;
            if (cmd_read && nbit > 5'h08 && nbit < 5'h11) rd_data <= {rd_data[6:0], sda_s[1]};
            frame <= {frame[16:0], 1'b0};
            scl_oe <= 1'b1; ph <= 2'h0; div <= 16'h0000;
            nbit <= nbit + 5'h01;
            if (nbit == 5'h11 || (nbit == 5'h08 && sda_s[1])) st <= M_STOP;
          end
        end
        M_STOP: begin
          div <= div + 16'h0001;
          if (div == 16'h0000) sda_oe <= 1'b1;
          else if (div == 16'(HALF_CYCLES)) scl_oe <= 1'b0;
          else if (div == 16'(2 * HALF_CYCLES)) begin
            sda_oe <= 1'b0; cmd_busy <= 1'b0; st <= M_IDLE;
          end
        end
        default: st <= M_IDLE;
      endcase
    end
  end
  assign bus.scl_m_oe = scl_oe;
  assign bus.sda_m_oe = sda_oe;
endmodule // two_wire_master

/* hw/two_wire_pkg.sv */
/*
  Shared constants for the two-wire slave and master ends.
  Assumes both ends are compiled after this package.
*/
package two_wire_pkg;
  localparam int unsigned BITS_PER_BYTE   = 8;
  localparam int unsigned ADDR_BITS       = 7;
  localparam int unsigned CLOCK_HZ        = 20_000_000;
  localparam int unsigned SCL_HZ          = 100_000;
  localparam int unsigned HALF_CYCLES     = CLOCK_HZ / (2 * SCL_HZ);
  localparam int unsigned WAKE_NS         = 1000;
  localparam int unsigned LINK_PERIOD_NS  = 12;
  localparam int unsigned WAKE_CYCLES     = (WAKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [6:0]  SLAVE_ADDR_RST  = 7'h2a;
  localparam logic        DIR_WRITE       = 1'b0;
  localparam logic        DIR_READ        = 1'b1;
endpackage

/* hw/two_wire_slave.sv */
/*
  Slave end of the two-wire bus, clocked by the link clock, with a
  byte-level user port on the system clock.
  Assumes the interface resolves wired-AND levels from the enables.
*/
// Overview of operation
// - Falling data while clock high starts transaction.
// - Rising data while clock high ends it.
// - Start without stop is repeated start.
// - Change data only while clock low.
// - Eight bits, MSB first, then acknowledge.
// - Receiver pulls data low on ninth clock.
// - Master sends seven-bit address plus direction.
// - Matching slave acknowledges; others stay released.
// - One address packet per start.
// - Direction bit selects write or read.
// - Data packets nine clocks, direction fixed.
// - Master stops writing after slave NACK.
// - Empty transaction after address is accepted.
// - Read: slave acks address, then sends bytes.
// - Master NACKs last read byte before stop.
// - Unlimited packets; combined segments via repeated start.
// - Stretch only after seeing clock already low.
// - Hold clock low during wake-up after start.
// - Slave may stretch at byte boundaries (the slave here stretches only during wake-up after start).
// - Wait while the other party holds clock.
// - Master starts on idle; yields on lost arbitration (the master here only raises lost and keeps driving its frame).
// - Slave takes no part in arbitration.
// - Slave role only; errors reported separately.
`timescale 1ns/100ps
module two_wire_slave
  import two_wire_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR   = SLAVE_ADDR_RST,
  parameter int unsigned WAKE_COUNT = WAKE_CYCLES
) (
  // Link side
  input  wire logic       link_clock,
  two_wire_if.slave       bus,
  // User side
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       asleep,
  input  wire logic [7:0] tx_byte,
  input  wire logic       rx_nack,
  output logic [7:0]      rx_byte,
  output logic            rx_toggle,
  output logic            dir_read,
  output logic            bus_busy,
  output logic            bus_error
);
  initial begin
    if (WAKE_COUNT < 1) $error("wake count must be at least one");
  end

  typedef enum {S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK, S_IGNORE} state_t;

  // ************************************************************
  // Link-domain synchronisers
  // ************************************************************
  logic [1:0] rst_sync;
  logic       lrst;
  logic [1:0] sleep_sync;
  logic [1:0] nack_sync;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] tx_s1;
  logic [7:0] tx_s2;
  // The transmit byte is a quasi-static level; two flops keep metastability off the engine.
  always_ff @(posedge link_clock) begin
    tx_s1      <= tx_byte;
    tx_s2      <= tx_s1;
    rst_sync   <= {rst_sync[0], rst};
    sleep_sync <= {sleep_sync[0], asleep};
    nack_sync  <= {nack_sync[0], rx_nack};
    scl_sync   <= {scl_sync[0], bus.scl};
    sda_sync   <= {sda_sync[0], bus.sda};
    scl_q      <= scl_sync[1];
    sda_q      <= sda_sync[1];
  end
  assign lrst = rst_sync[1];

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  assign start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  assign scl_rise   = scl_sync[1] & ~scl_q;
  assign scl_fall   = ~scl_sync[1] & scl_q;

  // ************************************************************
  // Link-domain protocol engine
  // ************************************************************
  state_t      state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic        dir;
  logic        busy_l;
  logic        err_l;
  logic        rx_tog_l;
  logic [7:0]  rx_l;
  logic        master_nack;
  logic [15:0] wake_cnt;
  logic        sda_drive;
  logic        scl_hold;

  // Busy flag follows start and stop only.
  always_ff @(posedge link_clock) begin
    if (lrst) busy_l <= 1'b0;
    else if (start_cond) busy_l <= 1'b1;
    else if (stop_cond) busy_l <= 1'b0;
  end

  // Wake-up stretch: clock is held only once it has been seen low.
  always_ff @(posedge link_clock) begin
    if (lrst) begin
      wake_cnt <= 16'h0000;
    end else if (start_cond && sleep_sync[1]) begin
      wake_cnt <= 16'(WAKE_COUNT);
    end else if (wake_cnt != 16'h0000 && (scl_hold || !scl_sync[1])) begin
      wake_cnt <= wake_cnt - 16'h0001;
    end
  end
  always_ff @(posedge link_clock) begin
    if (lrst) scl_hold <= 1'b0;
    else scl_hold <= (wake_cnt > 16'h0001) && (scl_hold || !scl_sync[1]);
  end

  always_ff @(posedge link_clock) begin
    if (lrst) begin
      state       <= S_IDLE;
      bit_cnt     <= 4'h0;
      shift       <= 8'h00;
      dir         <= DIR_WRITE;
      sda_drive   <= 1'b0;
      err_l       <= 1'b0;
      rx_tog_l    <= 1'b0;
      rx_l        <= 8'h00;
      master_nack <= 1'b0;
    end else if (start_cond) begin
      // Fresh or repeated start: exactly one address packet follows.
      state     <= S_ADDR;
      bit_cnt   <= 4'h0;
      sda_drive <= 1'b0;
    end else if (stop_cond) begin
      // Stop right after start, before any address bit, is a bus error.
      err_l     <= (state == S_ADDR) && (bit_cnt == 4'h0);
      state     <= S_IDLE;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          // Decide only after the eighth bit; the fall that follows a start carries none.
          if (scl_fall && bit_cnt == 4'h8) begin
            if (state == S_ADDR) begin
              if (shift[7:1] == OWN_ADDR) begin
                sda_drive <= 1'b1;
                dir       <= shift[0];
                state     <= S_AACK;
              end else begin
                state <= S_IGNORE;
              end
            end else begin
              rx_l      <= shift;
              rx_tog_l  <= ~rx_tog_l;
              sda_drive <= ~nack_sync[1];
              state     <= S_RACK;
            end
          end
        end
        S_AACK, S_RACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (dir == DIR_READ && state == S_AACK) begin
              sda_drive <= ~tx_s2[7];
              shift     <= {tx_s2[6:0], 1'b0};
              state     <= S_TX;
            end else begin
              sda_drive <= 1'b0;
              state     <= (state == S_RACK && nack_sync[1]) ? S_IGNORE : S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_rise) bit_cnt <= bit_cnt + 4'h1;
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_drive <= 1'b0;
              state     <= S_TACK;
            end else begin
              sda_drive <= ~shift[7];
              shift     <= {shift[6:0], 1'b0};
            end
          end
        end
        S_TACK: begin
          if (scl_rise) master_nack <= sda_sync[1];
          if (scl_fall) begin
            if (master_nack) begin
              state <= S_IGNORE;
            end else begin
              sda_drive <= ~tx_s2[7];
              shift     <= {tx_s2[6:0], 1'b0};
              bit_cnt   <= 4'h0;
              state     <= S_TX;
            end
          end
        end
        S_IDLE, S_IGNORE: sda_drive <= 1'b0;
        default: state <= S_IDLE;
      endcase
    end
  end
  assign bus.sda_s_oe = sda_drive;
  assign bus.scl_s_oe = scl_hold;

  // ************************************************************
  // Crossing to the user clock
  // ************************************************************
  logic [2:0] tog_sync;
  logic [1:0] busy_sync;
  logic [1:0] err_sync;
  logic [1:0] dir_sync;
  always_ff @(posedge clock) begin
    tog_sync  <= {tog_sync[1:0], rx_tog_l};
    busy_sync <= {busy_sync[0], busy_l};
    err_sync  <= {err_sync[0], err_l};
    dir_sync  <= {dir_sync[0], dir};
  end
  // Byte is stable long before the toggle lands, so it is sampled directly.
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_byte   <= 8'h00;
      rx_toggle <= 1'b0;
      dir_read  <= 1'b0;
      bus_busy  <= 1'b0;
      bus_error <= 1'b0;
    end else begin
      if (tog_sync[2] != tog_sync[1]) rx_byte <= rx_l;
      rx_toggle <= tog_sync[2];
      dir_read  <= dir_sync[1];
      bus_busy  <= busy_sync[1];
      bus_error <= err_sync[1];
    end
  end
endmodule // two_wire_slave

/* test/tb_two_wire_bus_slave_protocol.sv */
/*
  Testbench joining master and slave ends through the two-wire interface.
  Assumes the shared package and a slave wake-up count shortened to 2.
*/
`timescale 1ns/100ps
module tb_two_wire_bus_slave_protocol
  import two_wire_pkg::*;
;
  typedef struct packed {logic [6:0] a; logic rd; logic [7:0] d; logic nk; logic en;} row_t;
  logic       clock, link_clock, rst, cmd_valid, cmd_read, asleep, rx_nack, held, hit, tog;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data, tx_byte, rd_data, rx_byte;
  logic       cmd_busy, nacked, lost, rx_toggle, dir_read, bus_busy, bus_error;
  int         fails, total_checks;
  row_t       r;
  row_t       rows [5] = '{'{7'h2a, 1'b0, 8'ha5, 1'b0, 1'b0}, '{7'h2a, 1'b1, 8'h3c, 1'b0, 1'b0},
                           '{7'h15, 1'b0, 8'h5a, 1'b0, 1'b1}, '{7'h2a, 1'b0, 8'h81, 1'b1, 1'b1},
                           '{7'h2b, 1'b1, 8'hc3, 1'b0, 1'b1}};
  two_wire_if u_two_wire_if ();
  two_wire_master u_two_wire_master (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_data(cmd_data), .cmd_busy(cmd_busy),
    .rd_data(rd_data), .nacked(nacked), .lost(lost), .bus(u_two_wire_if));
  two_wire_slave #(.WAKE_COUNT(2)) u_two_wire_slave (.link_clock(link_clock),
    .bus(u_two_wire_if), .clock(clock), .rst(rst), .asleep(asleep), .tx_byte(tx_byte),
    .rx_nack(rx_nack), .rx_byte(rx_byte), .rx_toggle(rx_toggle), .dir_read(dir_read),
    .bus_busy(bus_busy), .bus_error(bus_error));
  two_wire_bus_slave_protocol_props u_props (.link_clock(link_clock), .rst(rst),
    .scl_m_oe(u_two_wire_if.scl_m_oe), .sda_m_oe(u_two_wire_if.sda_m_oe),
    .scl_s_oe(u_two_wire_if.scl_s_oe), .sda_s_oe(u_two_wire_if.sda_s_oe),
    .scl(u_two_wire_if.scl), .sda(u_two_wire_if.sda));
  // ****************************************
  // Clocks, monitor and helpers
  // ****************************************
  // The link clock starts off phase so no edge of it lines up with the system clock.
  initial begin clock = 1'b0; forever #25 clock = ~clock; end
  initial begin link_clock = 1'b0; #3.7; forever #6 link_clock = ~link_clock; end
  always @(posedge link_clock) if (u_two_wire_if.scl_s_oe === 1'b1) held = 1'b1;
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input logic [6:0] a, input logic rd, input logic [7:0] d);
    int n;
    cmd_addr = a; cmd_read = rd; cmd_data = d; cmd_valid = 1'b1;
    for (n = 0; n < 50 && cmd_busy !== 1'b1; n++) step(1);
    chk(cmd_busy, 8'h01);
    cmd_valid = 1'b0;
    step(600);
    chk(bus_busy, 8'h01);
    for (n = 0; n < 9000 && cmd_busy !== 1'b0; n++) step(1);
    chk(cmd_busy, 8'h00);
    step(20);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fails = 0; total_checks = 0; held = 1'b0; rst = 1'b1; cmd_valid = 1'b0;
    cmd_addr = 7'h00; cmd_read = 1'b0; cmd_data = 8'h00; asleep = 1'b0;
    tx_byte = 8'h00; rx_nack = 1'b0;
    step(4);
    rst = 1'b0;
    step(4);
    chk({cmd_busy, nacked, lost, rx_toggle, dir_read, bus_busy, bus_error}, 8'h00);
    foreach (rows[i]) begin
      r = rows[i]; tog = rx_toggle; hit = (r.a == SLAVE_ADDR_RST);
      tx_byte = r.d; rx_nack = r.nk;
      run(r.a, r.rd, r.d);
      chk(nacked, r.en);
      if (hit) chk(r.rd ? rd_data : rx_byte, r.d);
      if (hit) chk(dir_read, r.rd);
      chk(rx_toggle, tog ^ (hit & ~r.rd));
    end
    // Reset in mid-transaction must drop the bus back to idle.
    rx_nack = 1'b0; cmd_addr = 7'h2a; cmd_read = 1'b0; cmd_valid = 1'b1;
    step(2);
    cmd_valid = 1'b0;
    step(1500);
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    step(4);
    chk({cmd_busy, bus_busy}, 8'h00);
    // A sleeping slave must still take the transfer, holding the clock on wake-up.
    asleep = 1'b1; held = 1'b0; tog = rx_toggle;
    run(7'h2a, 1'b0, 8'h66);
    chk(held, 8'h01);
    chk(rx_byte, 8'h66);
    chk(rx_toggle, {7'h00, ~tog});
    chk({lost, bus_error}, 8'h00);
    test_done();
  end
  initial begin
    step(100000);
    fails++;
    test_done();
  end
endmodule // tb_two_wire_bus_slave_protocol

/* test/two_wire_bus_slave_protocol_props.sv */
/*
  Wire-level checks on the open-drain pair between master and slave.
  Assumes a single master and the slave address given by OWN_ADDR.
*/
`timescale 1ns/100ps
module two_wire_bus_slave_protocol_props
  import two_wire_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = SLAVE_ADDR_RST
) (
  // Clock and reset
  input wire logic link_clock,
  input wire logic rst,
  // Wires and enables
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************
  // Frame tracking
  // ****************************************
  // Sampling at the link clock is enough: bus phases last hundreds of link cycles.
  logic       scl_q;
  logic       sda_q;
  logic [4:0] cnt;
  logic [7:0] sh;
  logic       rd;
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;
  always_ff @(posedge link_clock) begin
    scl_q <= rst | scl;
    sda_q <= rst | sda;
  end
  always_ff @(posedge link_clock) begin
    if (rst | start) begin
      cnt <= 5'h00;
    end else if (rise) begin
      cnt <= cnt + 5'h01;
      sh  <= {sh[6:0], sda};
      if (cnt == 5'h08) begin
        rd <= sh[0];
      end
    end
  end
  default clocking @(posedge link_clock); endclocking
  default disable iff (rst);
  // ****************************************
  // Properties
  // ****************************************
  property p_sda_hold; scl && $past(scl) |-> $stable(sda_s_oe); endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("slave data moved in clock high");
  property p_sda_drive_low; $rose(sda_s_oe) |-> !scl; endproperty
  a_sda_drive_low: assert property (p_sda_drive_low) else $error("slave drove data in high");
  property p_stretch_low; $rose(scl_s_oe) |-> !$past(scl); endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("stretch before clock low");
  property p_start_master; scl && $fell(sda) |-> sda_m_oe && !sda_s_oe; endproperty
  a_start_master: assert property (p_start_master) else $error("start not by master");
  // The stop adds one clock rise after the last packet: 19 for two packets, 10 after an address NACK.
  property p_stop_frame; scl && $rose(sda) |-> cnt == 5'd19 || cnt == 5'd10; endproperty
  a_stop_frame: assert property (p_stop_frame) else $error("stop after wrong clock count");
  property p_addr_ack; rise && cnt == 5'h08 |-> sda == (sh[7:1] != OWN_ADDR); endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
  property p_read_nack; rise && cnt == 5'd17 && rd |-> sda; endproperty
  a_read_nack: assert property (p_read_nack) else $error("last read byte not nacked");
  property p_high_phase; $rose(scl) |-> scl[*8]; endproperty
  a_high_phase: assert property (p_high_phase) else $error("clock high phase too short");
endmodule // two_wire_bus_slave_protocol_props
